// >>> rtl/igcd_map.svh
// Command codes, field positions and reset values of the group decoder.
// Assumes it is included by bare name from files under rtl/.
// Overview of operation
// - 00011bbb clears indexed mask bit and request latch bit together
// - 00100xxx clears all mask bits so latched requests can raise
// - 00101bbb clears only the indexed mask bit
// - 00110xxx sets all mask bits; request output drops
// - 00111bbb sets only the indexed mask bit; its request drops
// - 01000xxx clears all request latch bits; request output drops
// - 01001bbb clears only the indexed request latch bit
// - 01010xxx sets all eight request latch bits
// - 01011bbb sets indexed request latch bit like a hardware request
// - 0110xxxx clears the highest-priority set in-service bit only
// - 01110xxx clears all in-service bits, removing the fence
// - 01111bbb clears indexed in-service bit; no effect if clear
// - 100xxxxx copies command bits 4..0 into mode bits 4..0
// - 1010 command loads bits 3 and 2 into mode bits 6 and 5
// - Arm code 00 keeps, 01 sets, 10 clears mode bit 7
// - 1011xxxx targets mask register for later data writes
// - 1100xxxx targets auto-clear register for later data writes
// - Preselects keep mode register; data reads keep write target
// - 111 command targets level vector memory and loads byte count
// - Level field selects request level zero to seven in binary
// - Commands come from command port writes, one port per group
// - Index field selects bit position zero to seven in binary
// - 00000000 sets mask, clears in-service, latch, auto-clear, mode
// - Group arm bit clear blocks requests without changing mask bits
`ifndef IGCD_MAP_SVH
`define IGCD_MAP_SVH
`define IGCD_CMD_RESET       8'h00
`define IGCD_OP5_CLR_BOTH1   5'h03
`define IGCD_OP5_CLR_MASK    5'h04
`define IGCD_OP5_CLR_MASK1   5'h05
`define IGCD_OP5_SET_MASK    5'h06
`define IGCD_OP5_SET_MASK1   5'h07
`define IGCD_OP5_CLR_REQ     5'h08
`define IGCD_OP5_CLR_REQ1    5'h09
`define IGCD_OP5_SET_REQ     5'h0A
`define IGCD_OP5_SET_REQ1    5'h0B
`define IGCD_OP4_CLR_TOP_IS  4'h6
`define IGCD_OP5_CLR_IS      5'h0E
`define IGCD_OP5_CLR_IS1     5'h0F
`define IGCD_OP3_MODE_LOW    3'h4
`define IGCD_OP4_MODE_HIGH   4'hA
`define IGCD_OP4_SEL_MASK    4'hB
`define IGCD_OP4_SEL_ACR     4'hC
`define IGCD_OP3_SEL_VEC     3'h7
`define IGCD_ARM_KEEP        2'h0
`define IGCD_ARM_SET         2'h1
`define IGCD_ARM_CLR         2'h2
`define IGCD_MODE_ARM_BIT    7
`define IGCD_MASK_RESET      8'hFF
`define IGCD_ZERO8           8'h00
`endif

// >>> rtl/igcd_pkg.sv
// Types shared by the group command decoder files.
// Assumes igcd_map.svh supplies the numeric constants.
package igcd_pkg;
   typedef enum logic [1:0] {
      IGCD_TGT_NONE = 2'b00,
      IGCD_TGT_MASK = 2'b01,
      IGCD_TGT_ACR  = 2'b10,
      IGCD_TGT_VEC  = 2'b11
   } igcd_target_t;
endpackage

// >>> rtl/igcd_vec_mem.sv
// Eight-entry vector byte memory with registered read data.
// Assumes writes and reads arrive on the decoder clock.
`timescale 1ns/1ps
module igcd_vec_mem (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       wr_en,
   input  wire logic [2:0] wr_level,
   input  wire logic [7:0] wr_data,
   input  wire logic [2:0] rd_level,
   output logic      [7:0] rd_data_q
);
   logic [7:0] mem_q [0:7];

   // Memory holds no reset so software reset leaves vectors intact
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_q[wr_level] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_q <= 8'h00;
      end else begin
         rd_data_q <= mem_q[rd_level];
      end
   end
endmodule

// >>> rtl/igcd_req_sync.sv
// Two-flop synchroniser and edge detector for the eight request pins.
// Assumes pins are asynchronous to clk.
`timescale 1ns/1ps
module igcd_req_sync (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] req_pins,
   input  wire logic       polarity_high,
   output logic      [7:0] req_edge
);
   logic [7:0] meta_q;
   logic [7:0] sync_q;
   logic [7:0] prev_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 8'h00;
         sync_q <= 8'h00;
         prev_q <= 8'h00;
      end else begin
         meta_q <= req_pins;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Only fresh transitions latch, never a standing level
   always_comb begin
      if (polarity_high) begin
         req_edge = sync_q & ~prev_q;
      end else begin
         req_edge = ~sync_q & prev_q;
      end
   end
endmodule

// >>> rtl/igcd_top.sv
// Command decoder of one eight-input priority interrupt group.
// Assumes the host writes command and data bytes on clk with one-cycle
// strobes; this group's command port is selected by the host's decode.
`timescale 1ns/1ps
`include "igcd_map.svh"
module igcd_top (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 cmd_wr,
   input  wire logic [7:0]           cmd_data,
   input  wire logic                 data_wr,
   input  wire logic                 data_rd,
   input  wire logic [7:0]           data_in,
   input  wire logic [7:0]           req_pins,
   output logic      [7:0]           data_out_q,
   output logic      [7:0]           mask_bits,
   output logic      [7:0]           request_latch_bits,
   output logic      [7:0]           in_service_bits,
   output logic      [7:0]           auto_clear_bits,
   output logic      [7:0]           mode_bits,
   output igcd_pkg::igcd_target_t    write_target,
   output logic      [2:0]           target_level,
   output logic      [2:0]           vector_count_of_level,
   output logic                      group_request
);
   import igcd_pkg::*;

   logic        rst_meta_q;
   logic        rst_sync_n;
   logic [7:0]  mask_q;
   logic [7:0]  irr_q;
   logic [7:0]  isr_q;
   logic [7:0]  acr_q;
   logic [7:0]  mode_q;
   igcd_target_t tgt_q;
   logic [2:0]  level_q;
   logic [1:0]  count_q [0:7];
   logic [7:0]  req_edge;
   logic [7:0]  vec_rd;
   logic [2:0]  rd_level_q;
   logic [7:0]  idx_onehot;
   logic [4:0]  op5;
   logic [3:0]  op4;
   logic [2:0]  op3;
   logic        vec_wr;

   // Plain binary index decode
   function automatic logic [7:0] onehot(input logic [2:0] idx);
      onehot = 8'h01 << idx;
   endfunction

   // Level 0 holds the highest priority
   function automatic logic [7:0] top_bit(input logic [7:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            r = 8'h00;
            r[i] = 1'b1;
         end
      end
      top_bit = r;
   endfunction

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n <= rst_meta_q;
      end
   end

   assign op5        = cmd_data[7:3];
   assign op4        = cmd_data[7:4];
   assign op3        = cmd_data[7:5];
   assign idx_onehot = onehot(cmd_data[2:0]);

   igcd_req_sync u_sync (
      .clk           (clk),
      .rst_n         (rst_sync_n),
      .req_pins      (req_pins),
      .polarity_high (mode_q[4]),
      .req_edge      (req_edge)
   );

   // Mask register
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mask_q <= `IGCD_MASK_RESET;
      end else if (cmd_wr) begin
         if (cmd_data == `IGCD_CMD_RESET) begin
            mask_q <= `IGCD_MASK_RESET;
         end else begin
            unique case (op5)
               `IGCD_OP5_CLR_BOTH1: mask_q <= mask_q & ~idx_onehot;
               `IGCD_OP5_CLR_MASK:  mask_q <= `IGCD_ZERO8;
               `IGCD_OP5_CLR_MASK1: mask_q <= mask_q & ~idx_onehot;
               `IGCD_OP5_SET_MASK:  mask_q <= `IGCD_MASK_RESET;
               `IGCD_OP5_SET_MASK1: mask_q <= mask_q | idx_onehot;
               default: mask_q <= mask_q;
            endcase
         end
      end else if (data_wr && tgt_q == IGCD_TGT_MASK) begin
         mask_q <= data_in;
      end
   end

   // Request latch: a pin edge in the same cycle wins over a clear
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irr_q <= 8'h00;
      end else if (cmd_wr) begin
         if (cmd_data == `IGCD_CMD_RESET) begin
            irr_q <= req_edge;
         end else begin
            unique case (op5)
               `IGCD_OP5_CLR_BOTH1:
                  irr_q <= (irr_q & ~idx_onehot) | req_edge;
               `IGCD_OP5_CLR_REQ:
                  irr_q <= req_edge;
               `IGCD_OP5_CLR_REQ1:
                  irr_q <= (irr_q & ~idx_onehot) | req_edge;
               `IGCD_OP5_SET_REQ:
                  irr_q <= 8'hFF;
               `IGCD_OP5_SET_REQ1:
                  irr_q <= irr_q | idx_onehot | req_edge;
               default:
                  irr_q <= irr_q | req_edge;
            endcase
         end
      end else begin
         irr_q <= irr_q | req_edge;
      end
   end

   // In-service bits are only cleared here; nothing in this design sets them
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         isr_q <= 8'h00;
      end else if (cmd_wr) begin
         if (cmd_data == `IGCD_CMD_RESET) begin
            isr_q <= 8'h00;
         end else if (op4 == `IGCD_OP4_CLR_TOP_IS) begin
            isr_q <= isr_q & ~top_bit(isr_q);
         end else if (op5 == `IGCD_OP5_CLR_IS) begin
            isr_q <= 8'h00;
         end else if (op5 == `IGCD_OP5_CLR_IS1) begin
            isr_q <= isr_q & ~idx_onehot;
         end
      end
   end

   // Auto-clear register
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         acr_q <= 8'h00;
      end else if (cmd_wr) begin
         if (cmd_data == `IGCD_CMD_RESET) begin
            acr_q <= 8'h00;
         end
      end else if (data_wr && tgt_q == IGCD_TGT_ACR) begin
         acr_q <= data_in;
      end
   end

   // Mode register
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mode_q <= 8'h00;
      end else if (cmd_wr) begin
         if (cmd_data == `IGCD_CMD_RESET) begin
            mode_q <= 8'h00;
         end else if (op3 == `IGCD_OP3_MODE_LOW) begin
            mode_q[4:0] <= cmd_data[4:0];
         end else if (op4 == `IGCD_OP4_MODE_HIGH) begin
            mode_q[6:5] <= cmd_data[3:2];
            unique case (cmd_data[1:0])
               `IGCD_ARM_SET: mode_q[`IGCD_MODE_ARM_BIT] <= 1'b1;
               `IGCD_ARM_CLR: mode_q[`IGCD_MODE_ARM_BIT] <= 1'b0;
               default:       mode_q[`IGCD_MODE_ARM_BIT] <=
                                 mode_q[`IGCD_MODE_ARM_BIT];
            endcase
         end
      end
   end

   // Write target; reads never touch it, and preselects skip mode
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tgt_q   <= IGCD_TGT_NONE;
         level_q <= 3'h0;
      end else if (cmd_wr) begin
         if (op4 == `IGCD_OP4_SEL_MASK) begin
            tgt_q <= IGCD_TGT_MASK;
         end else if (op4 == `IGCD_OP4_SEL_ACR) begin
            tgt_q <= IGCD_TGT_ACR;
         end else if (op3 == `IGCD_OP3_SEL_VEC) begin
            tgt_q   <= IGCD_TGT_VEC;
            level_q <= cmd_data[2:0];
         end else begin
            tgt_q <= IGCD_TGT_NONE;
         end
      end
   end

   // Byte counts survive the software reset command
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         for (int i = 0; i < 8; i++) begin
            count_q[i] <= 2'h0;
         end
      end else if (cmd_wr && op3 == `IGCD_OP3_SEL_VEC) begin
         count_q[cmd_data[2:0]] <= cmd_data[4:3];
      end
   end

   // Host is expected to write one vector byte per preselect
   assign vec_wr = data_wr && !cmd_wr && tgt_q == IGCD_TGT_VEC;

   igcd_vec_mem u_vec (
      .clk       (clk),
      .rst_n     (rst_sync_n),
      .wr_en     (vec_wr),
      .wr_level  (level_q),
      .wr_data   (data_in),
      .rd_level  (rd_level_q),
      .rd_data_q (vec_rd)
   );

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rd_level_q <= 3'h0;
      end else begin
         rd_level_q <= level_q;
      end
   end

   // Data port read picks a register by the readback select bits
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         data_out_q <= 8'h00;
      end else if (data_rd) begin
         unique case (mode_q[6:5])
            2'h0: data_out_q <= irr_q;
            2'h1: data_out_q <= isr_q;
            2'h2: data_out_q <= mask_q;
            2'h3: data_out_q <= acr_q;
         endcase
      end
   end

   // Disarmed group latches but raises nothing; mask bits kept
   assign group_request = mode_q[`IGCD_MODE_ARM_BIT] &&
                          |(irr_q & ~mask_q);

   assign mask_bits             = mask_q;
   assign request_latch_bits    = irr_q;
   assign in_service_bits       = isr_q;
   assign auto_clear_bits       = acr_q;
   assign mode_bits             = mode_q;
   assign write_target          = tgt_q;
   assign target_level          = level_q;
   assign vector_count_of_level = {1'b0, count_q[level_q]} + 3'h1;
endmodule

// >>> tb/igcd_top_monitor.sv
// Port-level checker of the group command decoder, bound to igcd_top.
// Assumes one clock and that commands wait for the internal reset release.
`timescale 1ns/1ps
module igcd_top_monitor
   import igcd_pkg::*;
(
   input wire logic         clk,
   input wire logic         rst_n,
   input wire logic         cmd_wr,
   input wire logic   [7:0] cmd_data,
   input wire logic         data_wr,
   input wire logic   [7:0] data_in,
   input wire logic   [7:0] mask_bits,
   input wire logic   [7:0] request_latch_bits,
   input wire logic   [7:0] in_service_bits,
   input wire logic   [7:0] mode_bits,
   input wire igcd_target_t write_target,
   input wire logic   [2:0] target_level,
   input wire logic   [2:0] vector_count_of_level,
   input wire logic         group_request
);
   logic [4:0] op;
   logic [7:0] bit1;
   assign op = cmd_data[7:3];
   assign bit1 = 8'h01 << cmd_data[2:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_CLR_BOTH1: assert property (cmd_wr && op == 5'h03 |=>
      mask_bits == ($past(mask_bits) & ~$past(bit1))
      && (request_latch_bits & $past(bit1)) == 8'h00) else $error("bit kept");
   AST_CLR_MASK: assert property (cmd_wr && op == 5'h04 |=>
      mask_bits == 8'h00) else $error("mask not cleared");
   AST_SET_MASK: assert property (cmd_wr && op == 5'h06 |=>
      mask_bits == 8'hFF && !group_request) else $error("mask not set");
   AST_SET_MASK1: assert property (cmd_wr && op == 5'h07 |=>
      mask_bits == ($past(mask_bits) | $past(bit1))) else $error("mask bit");
   AST_CLR_REQ: assert property (cmd_wr && op == 5'h08 |=>
      request_latch_bits == 8'h00 ##1 !group_request) else $error("latch");
   AST_SET_REQ: assert property (cmd_wr && op == 5'h0A |=>
      request_latch_bits == 8'hFF) else $error("latch not set");
   AST_MODE_LOW: assert property (cmd_wr && op[4:2] == 3'h4 |=>
      mode_bits == {$past(mode_bits[7:5]), $past(cmd_data[4:0])})
      else $error("mode low");
   AST_ARM: assert property (cmd_wr && op[4:1] == 4'hA |=>
      mode_bits[6:5] == $past(cmd_data[3:2]) && mode_bits[7] ==
      ($past(cmd_data[1:0]) == 2'h1 || ($past(cmd_data[1:0]) != 2'h2
      && $past(mode_bits[7])))) else $error("arm control");
   AST_SEL_KEEP: assert property (cmd_wr && op[4:1] inside {4'hB, 4'hC}
      |=> $stable(mode_bits) && write_target != IGCD_TGT_NONE)
      else $error("preselect");
   AST_VEC: assert property (cmd_wr && op[4:2] == 3'h7 |=>
      write_target == IGCD_TGT_VEC && target_level == $past(cmd_data[2:0])
      && vector_count_of_level == {1'b0, $past(cmd_data[4:3])} + 3'h1)
      else $error("vector preselect");
   AST_MASK_DATA: assert property (write_target == IGCD_TGT_MASK
      && data_wr && !cmd_wr |=> mask_bits == $past(data_in))
      else $error("mask data");
   AST_GRQ: assert property (group_request ==
      (mode_bits[7] && |(request_latch_bits & ~mask_bits)))
      else $error("group request");
   CV_VEC: cover property (cmd_wr && op[4:2] == 3'h7);
   CV_ARM: cover property (cmd_wr && cmd_data[7:4] == 4'hA && op[0] == 1'b0);
   CV_GRQ: cover property ($rose(group_request));
endmodule

bind igcd_top igcd_top_monitor i_igcd_top_monitor (
   .clk(clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
   .data_wr(data_wr), .data_in(data_in), .mask_bits(mask_bits),
   .request_latch_bits(request_latch_bits),
   .in_service_bits(in_service_bits), .mode_bits(mode_bits),
   .write_target(write_target), .target_level(target_level),
   .vector_count_of_level(vector_count_of_level),
   .group_request(group_request));

// >>> tb/igcd_host.sv
// Host model writing the command and data ports and reading the data port.
// Assumes the bench calls drive once per cycle and idles it at the end.
`timescale 1ns/1ps
module igcd_host (
   input  wire logic       clk,
   output logic            cmd_wr,
   output logic      [7:0] cmd_data,
   output logic            data_wr,
   output logic            data_rd,
   output logic      [7:0] data_in
);
   initial begin
      cmd_wr = 1'b0;
      cmd_data = 8'h00;
      data_wr = 1'b0;
      data_rd = 1'b0;
      data_in = 8'h00;
   end
   // Each call replaces the strobes at the next falling edge, so transfers
   // run back to back with no signal assigned twice in one step
   task automatic drive(input logic cw, input logic dw, input logic rd,
                        input logic [7:0] c, input logic [7:0] d);
      @(negedge clk);
      cmd_wr = cw;
      cmd_data = c;
      data_wr = dw;
      data_rd = rd;
      data_in = d;
   endtask
endmodule

// >>> tb/igcd_top_tb_top.sv
// Self-checking bench of the group command decoder with a result queue.
// Assumes igcd_host drives the ports and the monitor is bound to igcd_top.
`timescale 1ns/1ps
module igcd_top_tb_top;
   import igcd_pkg::*;
   logic         clk, rst_n, cmd_wr, data_wr, data_rd, group_request;
   logic   [7:0] cmd_data, data_in, req_pins, data_out_q, mask_bits;
   logic   [7:0] request_latch_bits, in_service_bits, auto_clear_bits;
   logic   [7:0] mode_bits, e_msk, e_lat, e_isv, e_acr, e_mod, c, d;
   igcd_target_t write_target;
   logic   [1:0] e_tgt;
   logic   [2:0] target_level, vector_count_of_level, e_lvl, e_cnt;
   logic  [47:0] notes[$];
   integer       err_total, checks, seed, k;
   igcd_host i_igcd_host (.clk(clk), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
      .data_wr(data_wr), .data_rd(data_rd), .data_in(data_in));
   igcd_top i_igcd_top (.clk(clk), .rst_n(rst_n), .cmd_wr(cmd_wr),
      .cmd_data(cmd_data), .data_wr(data_wr), .data_rd(data_rd),
      .data_in(data_in), .req_pins(req_pins), .data_out_q(data_out_q),
      .mask_bits(mask_bits), .request_latch_bits(request_latch_bits),
      .in_service_bits(in_service_bits), .auto_clear_bits(auto_clear_bits),
      .mode_bits(mode_bits), .write_target(write_target),
      .target_level(target_level),
      .vector_count_of_level(vector_count_of_level),
      .group_request(group_request));
   task automatic check(input string what, input logic [47:0] seen,
                        input logic [47:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic [47:0] snap();
      return {e_msk, e_lat, e_isv, e_acr, e_mod, e_tgt, e_lvl, e_cnt};
   endfunction
   task automatic apply(input logic [7:0] v);
      logic [2:0] i;
      i = v[2:0];
      if (v[7:5] != 3'h7 && v[7:4] != 4'hB && v[7:4] != 4'hC) e_tgt = 2'h0;
      if (v == 8'h00) begin
         e_msk = 8'hFF;
         {e_lat, e_isv, e_acr, e_mod} = 32'h0;
      end else case (v[7:3])
         5'h03: {e_msk[i], e_lat[i]} = 2'b00;
         5'h04: e_msk = 8'h00;
         5'h05: e_msk[i] = 1'b0;
         5'h06: e_msk = 8'hFF;
         5'h07: e_msk[i] = 1'b1;
         5'h08: e_lat = 8'h00;
         5'h09: e_lat[i] = 1'b0;
         5'h0A: e_lat = 8'hFF;
         5'h0B: e_lat[i] = 1'b1;
         5'h0C, 5'h0D: e_isv = e_isv & (e_isv - 8'h01);
         5'h0E: e_isv = 8'h00;
         5'h0F: e_isv[i] = 1'b0;
         5'h10, 5'h11, 5'h12, 5'h13: e_mod[4:0] = v[4:0];
         5'h14, 5'h15: begin
            e_mod[6:5] = v[3:2];
            // Code 11 is treated like 00 so the arm bit keeps its value, as in the design
            if (v[1:0] != 2'h3) e_mod[7] = v[0] ? 1'b1 : (v[1] ? 1'b0 : e_mod[7]);
         end
         5'h16, 5'h17: e_tgt = 2'h1;
         5'h18, 5'h19: e_tgt = 2'h2;
         5'h1C, 5'h1D, 5'h1E, 5'h1F: begin
            {e_tgt, e_lvl} = {2'h3, v[2:0]};
            e_cnt = {1'b0, v[4:3]} + 3'h1;
         end
         default: ;
      endcase
   endtask
   task automatic do_cmd(input logic [7:0] v, input logic both,
                         input logic [7:0] dv);
      i_igcd_host.drive(1'b1, both, 1'b0, v, dv);
      apply(v);
      notes.push_back(snap());
   endtask
   task automatic do_dw(input logic [7:0] dv);
      i_igcd_host.drive(1'b0, 1'b1, 1'b0, 8'h00, dv);
      if (e_tgt == 2'h1) e_msk = dv;
      else if (e_tgt == 2'h2) e_acr = dv;
      notes.push_back(snap());
   endtask
   task automatic do_rd();
      i_igcd_host.drive(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
      notes.push_back({40'h0, e_mod[6] ? (e_mod[5] ? e_acr : e_msk)
                                       : (e_mod[5] ? e_isv : e_lat)});
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      logic w, r;
      logic [47:0] n;
      forever begin
         @(posedge clk);
         {w, r} = {cmd_wr | data_wr, data_rd};
         #1;
         if (w | r) begin
            n = notes.pop_front();
            if (r) check("readback", {40'h0, data_out_q}, n);
            else check("state", {mask_bits, request_latch_bits, in_service_bits, auto_clear_bits, mode_bits, write_target, target_level, vector_count_of_level}, n);
         end
      end
   end
   initial begin
      #80000;
      err_total++;
      final_report();
   end
   initial begin
      {seed, err_total, checks} = {32'h5987c16f, 32'h0, 32'h0};
      {rst_n, req_pins} = {1'b0, 8'hFF};
      {e_msk, e_lat, e_isv, e_acr, e_mod} = {8'hFF, 32'h0};
      {e_tgt, e_lvl, e_cnt} = 8'h01;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      check("reset", {mask_bits, request_latch_bits, in_service_bits,
            auto_clear_bits, mode_bits, write_target, target_level,
            vector_count_of_level}, {8'hFF, 37'h0, 3'h1});
      do_cmd(8'hE5, 1'b0, 8'h00);
      do_dw(8'h40);
      i_igcd_host.drive(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      d = 8'($random(seed));
      req_pins = d;
      e_lat = e_lat | ~d;
      repeat (6) @(negedge clk);
      req_pins = 8'hFF;
      repeat (6) @(negedge clk);
      do_cmd(8'hC0, 1'b0, 8'h00);
      for (k = 3; k < 32; k++) begin
         do_cmd({k[4:0], 3'($random(seed))}, 1'b0, 8'h00);
         do_rd();
         do_dw(8'($random(seed)));
      end
      for (k = 0; k < 150; k++) begin
         c = {5'(3 + $unsigned($random(seed)) % 29), 3'($random(seed))};
         d = 8'($random(seed));
         do_cmd(c, d[7], d);
         if (d[6]) do_rd();
         if (d[5]) do_dw(d ^ 8'h5A);
      end
      do_cmd(8'h00, 1'b0, 8'h00);
      i_igcd_host.drive(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      repeat (4) @(negedge clk);
      final_report();
   end
endmodule
